// >>> tcm_timer.v
// Behaviour
// - A counter write blocks every compare match in the following timer cycle.
// - Output-action field takes effect at once, no double buffering.
// - System reset clears the compare output state to zero.
// - Nonzero action field puts output state on pin; direction bit still rules.
// - Pin override acts the same in every waveform mode.
// - Output states keep their values across waveform mode changes.
// - Action field zero leaves output state unchanged on a match.
// - New action setting governs from the first match after the write.
// - Force strobe applies configured action at once in non-PWM modes.
// - Counting depends only on waveform mode, never on action field.
// - Mode 0 counts up always and wraps from 0xFF to 0x00.
// - Normal mode sets overflow flag when count becomes zero; only sets.
// - Normal mode accepts a counter write at any time.
// - Mode 2 clears counter on match with compare A, its top.
// - Compare A below count makes counter run to 0xFF and wrap.
// - Clear-on-match mode raises compare A flag at each top reach.
// - Action 1 in clear-on-match mode toggles output A on each match.
// - Prescale divisor selectable among 1, 8, 64, 256 and 1024.
// - Clear-on-match mode sets overflow flag on move from max to 0x00.
// - Counter write has priority over hardware clear or count.
// - A match sets its compare flag at the next timer cycle.
// - Compare flag clears by writing one or on interrupt service.
// - Forced compare updates output but no flag and no counter change.
`timescale 1ns/1ps
`include "tcm_defs.vh"

module tcm_timer (
    // Clock and reset
    input  wire       MCLK_I,
    input  wire       RST_I,
    // Configuration
    input  wire [2:0] WAVEFORM_MODE_I,
    input  wire [2:0] CLOCK_SELECT_I,
    input  wire [1:0] ACTION_A_I,
    input  wire [1:0] ACTION_B_I,
    input  wire [7:0] COMPARE_A_VALUE_I,
    input  wire [7:0] COMPARE_B_VALUE_I,
    // Counter write port
    input  wire       COUNT_WR_I,
    input  wire [7:0] COUNT_WDATA_I,
    // Force strobes
    input  wire       FORCE_A_I,
    input  wire       FORCE_B_I,
    // Flag clears: write-one or interrupt service
    input  wire       OVF_CLR_I,
    input  wire       CMPA_CLR_I,
    input  wire       CMPB_CLR_I,
    input  wire       OVF_ACK_I,
    input  wire       CMPA_ACK_I,
    input  wire       CMPB_ACK_I,
    // Port pin data and direction
    input  wire       PORT_A_DATA_I,
    input  wire       PORT_A_DIR_I,
    input  wire       PORT_B_DATA_I,
    input  wire       PORT_B_DIR_I,
    // Status
    output reg  [7:0] TIMER_COUNT_O,
    output reg        OVERFLOW_FLAG_O,
    output reg        COMPARE_A_FLAG_O,
    output reg        COMPARE_B_FLAG_O,
    output wire       COMPARE_A_OUTPUT_O,
    output wire       COMPARE_B_OUTPUT_O,
    // Pins
    output wire       PIN_A_O,
    output wire       PIN_A_OE_O,
    output wire       PIN_B_O,
    output wire       PIN_B_OE_O
);

    wire       timer_tick;
    reg        block_match;
    reg  [7:0] next_count;
    reg        next_ovf;
    wire       non_pwm;
    wire       ctc_mode;
    wire       match_a;
    wire       match_b;
    wire       flag_a_set;
    wire       flag_b_set;
    wire       force_a;
    wire       force_b;
    wire       top_clear;
    reg        next_ovf_flag;
    reg        next_cmpa_flag;
    reg        next_cmpb_flag;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // One compare channel: equality seen only on a tick that no write blocks
    // Shared by both channels so A and B can never decode a match differently
    function match_hit;
        input       tick;
        input       blocked;
        input [7:0] count;
        input [7:0] value;
        begin
            match_hit = tick & ~blocked & (count == value);
        end
    endfunction

    // Leaving MAX is the only overflow step, whether by count or by clear
    // at a top of MAX; both counting branches ask the same question
    function at_wrap;
        input [7:0] count;
        begin
            at_wrap = (count == `TCM_MAX);
        end
    endfunction

    // A flag clears on a write of one or when its interrupt is serviced
    // Both sources are plain pulses of the same clock, so no edge detect
    // either clear source
    function clear_req;
        input wr_one;
        input serviced;
        begin
            clear_req = wr_one | serviced;
        end
    endfunction

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Stop codes hold the divider at zero, so a restart begins a full period
    // Only the internal divider ticks; there is no external count source
    // selectable divisor
    tcm_prescaler u_prescaler (
        .clk_i  (MCLK_I),
        .rst_i  (RST_I),
        .sel_i  (CLOCK_SELECT_I),
        .tick_o (timer_tick)
    );

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Codes other than 0 and 2 run as Normal here; no PWM waveform is built,
    // and those codes take no force strobe
    // mode field only
    assign ctc_mode = (WAVEFORM_MODE_I == `TCM_WGM_CTC);
    assign non_pwm  = (WAVEFORM_MODE_I == `TCM_WGM_NORMAL) | ctc_mode;

    // Matches are seen only on tick edges and not in a blocked cycle
    // A write on the same edge as a tick blocks the tick after, not this one
    // write blocks match
    assign match_a = match_hit(timer_tick, block_match, TIMER_COUNT_O, COMPARE_A_VALUE_I);
    assign match_b = match_hit(timer_tick, block_match, TIMER_COUNT_O, COMPARE_B_VALUE_I);

    // A force reaches only the output units; it never touches count or flags
    // force in non-PWM only
    assign force_a = FORCE_A_I & non_pwm;
    assign force_b = FORCE_B_I & non_pwm;

    // ----------------------------------------------------------------
    // Match blocking
    // ----------------------------------------------------------------
    // Held until the next tick consumes it, so a stopped timer still blocks
    // Writing a count equal to a compare value therefore loses that match;
    // the waveform then misses one edge, which software must allow for
    // block next tick
    always @(posedge MCLK_I) begin
        if (RST_I) begin
            block_match <= 1'b0;
        end else if (COUNT_WR_I) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Clear-on-match top reached on this tick; a blocked match never clears
    // clear at top
    assign top_clear = ctc_mode & match_a;

    // Next count: a write first, then a clear at top, else a step by one
    // A tick that meets a write is lost, as the write priority intends
    always @* begin
        next_count = TIMER_COUNT_O;
        next_ovf   = 1'b0;
        if (COUNT_WR_I) begin
            next_count = COUNT_WDATA_I;
        end else if (timer_tick) begin
            if (top_clear) begin
                next_count = `TCM_BOTTOM;
                // A top of MAX clears from MAX, which is an overflow too
                next_ovf   = at_wrap(TIMER_COUNT_O);
            end else begin
                next_count = TIMER_COUNT_O + 8'h01;
                next_ovf   = at_wrap(TIMER_COUNT_O);
            end
        end
    end

    // The count register drives its port directly, so readers see no glitch
    // tick qualified count
    always @(posedge MCLK_I) begin
        if (RST_I) begin
            TIMER_COUNT_O <= `TCM_RST_COUNT;
        end else begin
            TIMER_COUNT_O <= next_count;
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    // Forced compare never reaches these terms
    // force sets no flag
    assign flag_a_set = match_a;
    assign flag_b_set = match_b;

    // Set wins over a clear in the same cycle, so no event is ever lost
    // Set terms come only from tick edges, never from a force strobe
    // write-one or service clears
    always @* begin
        next_ovf_flag  = OVERFLOW_FLAG_O;
        next_cmpa_flag = COMPARE_A_FLAG_O;
        next_cmpb_flag = COMPARE_B_FLAG_O;
        if (clear_req(OVF_CLR_I, OVF_ACK_I)) begin
            next_ovf_flag = 1'b0;
        end
        if (clear_req(CMPA_CLR_I, CMPA_ACK_I)) begin
            next_cmpa_flag = 1'b0;
        end
        if (clear_req(CMPB_CLR_I, CMPB_ACK_I)) begin
            next_cmpb_flag = 1'b0;
        end
        if (next_ovf) begin
            next_ovf_flag = 1'b1;
        end
        if (flag_a_set) begin
            next_cmpa_flag = 1'b1;
        end
        if (flag_b_set) begin
            next_cmpb_flag = 1'b1;
        end
    end

    // Flag registers; the outputs are these flip-flops with nothing after
    always @(posedge MCLK_I) begin
        if (RST_I) begin
            OVERFLOW_FLAG_O  <= 1'b0;
            COMPARE_A_FLAG_O <= 1'b0;
            COMPARE_B_FLAG_O <= 1'b0;
        end else begin
            OVERFLOW_FLAG_O  <= next_ovf_flag;
            COMPARE_A_FLAG_O <= next_cmpa_flag;
            COMPARE_B_FLAG_O <= next_cmpb_flag;
        end
    end

    // ----------------------------------------------------------------
    // Output units
    // ----------------------------------------------------------------
    // Each unit holds its own state flip-flop and no mode change resets it;
    // that is what carries the state across waveform mode switches
    // toggle on match
    tcm_outunit u_out_a (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .action_i    (ACTION_A_I),
        .match_i     (match_a),
        .force_i     (force_a),
        .port_data_i (PORT_A_DATA_I),
        .port_dir_i  (PORT_A_DIR_I),
        .state_o     (COMPARE_A_OUTPUT_O),
        .pin_o       (PIN_A_O),
        .pin_oe_o    (PIN_A_OE_O)
    );

    tcm_outunit u_out_b (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .action_i    (ACTION_B_I),
        .match_i     (match_b),
        .force_i     (force_b),
        .port_data_i (PORT_B_DATA_I),
        .port_dir_i  (PORT_B_DIR_I),
        .state_o     (COMPARE_B_OUTPUT_O),
        .pin_o       (PIN_B_O),
        .pin_oe_o    (PIN_B_OE_O)
    );

endmodule // tcm_timer

// >>> tcm_defs.vh
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// Counter extremes
`define TCM_BOTTOM        8'h00
`define TCM_MAX           8'hFF

// Waveform mode codes
`define TCM_WGM_NORMAL    3'h0
`define TCM_WGM_CTC       3'h2
`define TCM_WGM_W         3

// Output-action codes, non-PWM meaning
`define TCM_COM_NONE      2'h0
`define TCM_COM_TOGGLE    2'h1
`define TCM_COM_CLEAR     2'h2
`define TCM_COM_SET       2'h3

// Prescale select codes
`define TCM_CS_STOP       3'h0
`define TCM_CS_DIV1       3'h1
`define TCM_CS_DIV8       3'h2
`define TCM_CS_DIV64      3'h3
`define TCM_CS_DIV256     3'h4
`define TCM_CS_DIV1024    3'h5

// Prescale divisor terminal counts (divisor minus one)
`define TCM_PS_W          10
`define TCM_PS_TC8        10'h007
`define TCM_PS_TC64       10'h03F
`define TCM_PS_TC256      10'h0FF
`define TCM_PS_TC1024     10'h3FF

// Reset values
`define TCM_RST_COUNT     8'h00
`define TCM_RST_OC        1'b0

`endif

// >>> tcm_prescaler.v
`timescale 1ns/1ps
`include "tcm_defs.vh"

module tcm_prescaler (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Divisor select
    input  wire [2:0] sel_i,
    // Timer tick enable
    output reg        tick_o
);

    reg  [`TCM_PS_W-1:0] div_cnt;
    reg  [`TCM_PS_W-1:0] term;

    // ----------------------------------------------------------------
    // Terminal count per divisor
    // ----------------------------------------------------------------
    always @* begin
        case (sel_i)
            `TCM_CS_DIV8:    term = `TCM_PS_TC8;
            `TCM_CS_DIV64:   term = `TCM_PS_TC64;
            `TCM_CS_DIV256:  term = `TCM_PS_TC256;
            `TCM_CS_DIV1024: term = `TCM_PS_TC1024;
            default:         term = {`TCM_PS_W{1'b0}};
        endcase
    end

    // Free running divider; select codes above DIV1024 stop the timer
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= {`TCM_PS_W{1'b0}};
            tick_o  <= 1'b0;
        end else if (sel_i == `TCM_CS_STOP || sel_i > `TCM_CS_DIV1024) begin
            div_cnt <= {`TCM_PS_W{1'b0}};
            tick_o  <= 1'b0;
        end else if (div_cnt >= term) begin
            div_cnt <= {`TCM_PS_W{1'b0}};
            tick_o  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + {{(`TCM_PS_W-1){1'b0}}, 1'b1};
            tick_o  <= 1'b0;
        end
    end

endmodule // tcm_prescaler

// >>> tcm_outunit.v
`timescale 1ns/1ps
`include "tcm_defs.vh"

module tcm_outunit (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Action control
    input  wire [1:0] action_i,
    input  wire       match_i,
    input  wire       force_i,
    // Port pin inputs
    input  wire       port_data_i,
    input  wire       port_dir_i,
    // Results
    output reg        state_o,
    output reg        pin_o,
    output reg        pin_oe_o
);

    reg next_state;
    reg hit;

    // ----------------------------------------------------------------
    // Waveform generator
    // ----------------------------------------------------------------
    // immediate action use
    always @* begin
        hit = match_i | force_i;
        next_state = state_o;
        if (hit) begin
            case (action_i)
                `TCM_COM_NONE:   next_state = state_o;
                `TCM_COM_TOGGLE: next_state = ~state_o;
                `TCM_COM_CLEAR:  next_state = 1'b0;
                `TCM_COM_SET:    next_state = 1'b1;
                default:         next_state = state_o;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_o <= `TCM_RST_OC;
        end else begin
            state_o <= next_state;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= (action_i != `TCM_COM_NONE) ? next_state : port_data_i;
            pin_oe_o <= port_dir_i;
        end
    end

endmodule // tcm_outunit

// >>> tcm_timer_props.sv
`timescale 1ns/1ps
module tcm_timer_props (
    // Clock and reset
    input wire       MCLK_I,
    input wire       RST_I,
    // Controls
    input wire [2:0] WAVEFORM_MODE_I,
    input wire [2:0] CLOCK_SELECT_I,
    input wire [1:0] ACTION_A_I,
    input wire       COUNT_WR_I,
    input wire [7:0] COUNT_WDATA_I,
    input wire       FORCE_A_I,
    input wire       OVF_CLR_I,
    input wire       OVF_ACK_I,
    input wire       CMPA_CLR_I,
    input wire       PORT_A_DATA_I,
    input wire       PORT_A_DIR_I,
    // Results
    input wire [7:0] TIMER_COUNT_O,
    input wire       OVERFLOW_FLAG_O,
    input wire       COMPARE_A_FLAG_O,
    input wire       COMPARE_A_OUTPUT_O,
    input wire       PIN_A_O,
    input wire       PIN_A_OE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    reg [2:0] stop_hist;
    // Stopped this cycle and the three before, so no tick can still be in flight
    always @(posedge MCLK_I) begin
        stop_hist <= {stop_hist[1:0], CLOCK_SELECT_I == 3'h0};
    end
    wire idle = (CLOCK_SELECT_I == 3'h0) && (stop_hist == 3'h7);
    a_count_write_lands: assert property (COUNT_WR_I |=>
        TIMER_COUNT_O == $past(COUNT_WDATA_I)) else $error("count write lost");
    a_stopped_count_holds: assert property (idle && !COUNT_WR_I |=>
        $stable(TIMER_COUNT_O)) else $error("count moved while stopped");
    a_overflow_sticky: assert property (OVERFLOW_FLAG_O && !OVF_CLR_I && !OVF_ACK_I
        |=> OVERFLOW_FLAG_O) else $error("overflow flag dropped");
    a_flag_a_clears: assert property (idle && CMPA_CLR_I |=> !COMPARE_A_FLAG_O)
        else $error("compare flag not cleared");
    a_oe_follows_dir: assert property (1'b1 |=>
        PIN_A_OE_O == $past(PORT_A_DIR_I)) else $error("pin enable wrong");
    a_pin_port_data: assert property (ACTION_A_I == 2'h0 |=>
        PIN_A_O == $past(PORT_A_DATA_I)) else $error("pin not port data");
    a_pin_state: assert property (ACTION_A_I != 2'h0 |=>
        PIN_A_O == COMPARE_A_OUTPUT_O) else $error("pin not output state");
    a_force_toggles: assert property (idle && FORCE_A_I && ACTION_A_I == 2'h1
        && WAVEFORM_MODE_I == 3'h0 |=> COMPARE_A_OUTPUT_O != $past(COMPARE_A_OUTPUT_O)
        && !$rose(COMPARE_A_FLAG_O)) else $error("force did not toggle");
endmodule // tcm_timer_props

bind tcm_timer tcm_timer_props u_props (.*);

// >>> tcm_pin_model.sv
`timescale 1ns/1ps
module tcm_pin_model (
    // Clock
    input  wire       clk_i,
    // Wanted port settings
    input  wire [1:0] dat_i,
    input  wire [1:0] dir_i,
    // Timer pin drive
    input  wire [1:0] pin_i,
    input  wire [1:0] oe_i,
    // Port registers and pads
    output reg  [1:0] port_dat_o,
    output reg  [1:0] port_dir_o,
    output wire [1:0] pad_o
);
    // Port registers load on the clock like software writes
    always @(posedge clk_i) begin
        port_dat_o <= dat_i;
        port_dir_o <= dir_i;
    end
    // direction gates pad
    // Undriven pad rests at its pull-up, never at a stale value
    assign pad_o = (oe_i & pin_i) | ~oe_i;
endmodule // tcm_pin_model

// >>> timer_compare_output_normal_ctc_bench.sv
`timescale 1ns/1ps
module timer_compare_output_normal_ctc_bench;
    reg        MCLK_I = 1'h0;
    reg        RST_I = 1'h1;
    reg  [2:0] mode = 3'h0;
    reg  [2:0] cs = 3'h0;
    reg  [1:0] act_a = 2'h0;
    reg  [1:0] act_b = 2'h0;
    reg  [7:0] cmp_a = 8'h00;
    reg        wr = 1'h0;
    reg  [7:0] wdat = 8'h00;
    reg  [1:0] frc = 2'h0;
    reg  [3:0] clr = 4'h0;
    reg  [1:0] dat = 2'h0;
    reg  [1:0] dir = 2'h0;
    wire [1:0] pdat, pdir, pin, oe, pad;
    wire [7:0] cnt;
    wire       ovf, fla, flb, sta, stb;
    integer    err_total = 0, n_tests = 0, i, t, mx;
    // Clock at 125 MHz
    always #4 MCLK_I = ~MCLK_I;
    tcm_timer dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .WAVEFORM_MODE_I(mode),
        .CLOCK_SELECT_I(cs), .ACTION_A_I(act_a), .ACTION_B_I(act_b),
        .COMPARE_A_VALUE_I(cmp_a), .COMPARE_B_VALUE_I(8'h80), .COUNT_WR_I(wr),
        .COUNT_WDATA_I(wdat), .FORCE_A_I(frc[0]), .FORCE_B_I(frc[1]), .OVF_CLR_I(clr[0]),
        .CMPA_CLR_I(clr[1]), .CMPB_CLR_I(1'h0), .OVF_ACK_I(clr[2]), .CMPA_ACK_I(clr[3]),
        .CMPB_ACK_I(1'h0), .PORT_A_DATA_I(pdat[0]), .PORT_A_DIR_I(pdir[0]),
        .PORT_B_DATA_I(pdat[1]), .PORT_B_DIR_I(pdir[1]), .TIMER_COUNT_O(cnt),
        .OVERFLOW_FLAG_O(ovf), .COMPARE_A_FLAG_O(fla), .COMPARE_B_FLAG_O(flb),
        .COMPARE_A_OUTPUT_O(sta), .COMPARE_B_OUTPUT_O(stb), .PIN_A_O(pin[0]),
        .PIN_A_OE_O(oe[0]), .PIN_B_O(pin[1]), .PIN_B_OE_O(oe[1]));
    tcm_pin_model pm (.clk_i(MCLK_I), .dat_i(dat), .dir_i(dir), .pin_i(pin), .oe_i(oe),
        .port_dat_o(pdat), .port_dir_o(pdir), .pad_o(pad));
    // Inputs always move 1 ns after the rising edge
    task cyc(input integer n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask
    task chk(input [79:0] nm, input [15:0] exp, input [15:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %0s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task put(input [7:0] v, input [3:0] c);
        wdat = v;
        wr = 1'h1;
        clr = c;
        cyc(1);
        wr = 1'h0;
        clr = 4'h0;
    endtask
    // Cycles between two count steps, the first wait absorbs the restart
    task meas(input [2:0] sel, input [15:0] div);
        cs = sel;
        for (i = 0; i < 3000 && cnt == t; i = i + 1) cyc(1);
        t = cnt;
        for (i = 0; i < 3000 && cnt == t; i = i + 1) cyc(1);
        t = cnt;
        chk("prescale", div, i[15:0]);
    endtask
    task stop;
        cs = 3'h0;
        cyc(4);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        cyc(20000);
        err_total = err_total + 1;
        conclude;
    end
    initial begin
        cyc(10);
        RST_I = 1'h0;
        cyc(1);
        chk("count_rst", 8'h00, cnt);
        chk("state_rst", 1'h0, sta);
        cmp_a = 8'h10;
        put(8'h10, 4'h0);
        cyc(4);
        chk("count_wr", 8'h10, cnt);
        cs = 3'h1;
        cyc(6);
        chk("blocked", 1'h0, fla);
        cyc(300);
        chk("ovf_wrap", 1'h1, ovf);
        chk("flag_a", 1'h1, fla);
        chk("flag_b", 1'h1, flb);
        stop;
        clr = 4'h9;
        cyc(1);
        clr = 4'h0;
        chk("ovf_clr", 1'h0, ovf);
        chk("fla_ack", 1'h0, fla);
        t = cnt;
        meas(3'h1, 1);
        meas(3'h2, 8);
        meas(3'h3, 64);
        meas(3'h4, 256);
        meas(3'h5, 1024);
        stop;
        put(8'h00, 4'h2);
        mode = 3'h2;
        cmp_a = 8'h03;
        act_a = 2'h1;
        dir = 2'h3;
        dat = 2'h1;
        cs = 3'h1;
        cyc(3);
        t = sta;
        for (i = 0; i < 20 && sta === t; i = i + 1) cyc(1);
        t = sta;
        mx = 0;
        for (i = 0; i < 20 && sta === t; i = i + 1) begin
            cyc(1);
            if (cnt > mx) mx = cnt;
        end
        chk("half_per", 4, i[15:0]);
        chk("ctc_top", 3, mx[15:0]);
        chk("fla_ctc", 1'h1, fla);
        chk("pad_a", 1'h0, pad[0]);
        stop;
        put(8'h10, 4'h4);
        cs = 3'h1;
        cyc(100);
        chk("above_top", 1'h1, cnt > 8'h10);
        chk("ovf_early", 1'h0, ovf);
        cyc(200);
        chk("ovf_ctc", 1'h1, ovf);
        chk("wrapped", 1'h1, cnt <= 8'h03);
        stop;
        put(cnt, 4'h2);
        mode = 3'h0;
        t = cnt;
        // Clear, set, none, toggle, set; on none each pad falls back to port data
        for (i = 0; i < 5; i = i + 1) begin
            act_a = 10'h2C7 >> (8 - 2 * i);
            act_b = act_a;
            frc = 2'h3;
            cyc(1);
            frc = 2'h0;
            cyc(1);
            chk("force_a", 5'h0D >> (4 - i) & 1, sta);
            chk("force_b", 5'h0D >> (4 - i) & 1, stb);
            chk("pad_fa", 5'h0D >> (4 - i) & 1, pad[0]);
            chk("pad_fb", 5'h09 >> (4 - i) & 1, pad[1]);
        end
        chk("no_flag", 1'h0, fla);
        chk("no_count", t[7:0], cnt);
        mode = 3'h2;
        cyc(3);
        mode = 3'h0;
        cyc(1);
        chk("mode_keep", 1'h1, sta);
        act_a = 2'h0;
        dat = 2'h0;
        cyc(4);
        chk("pad_data", 1'h0, pad[0]);
        dir = 2'h0;
        dat = 2'h0;
        cyc(4);
        chk("pad_float", 1'h1, pad[0]);
        conclude;
    end
endmodule // timer_compare_output_normal_ctc_bench
